// >>> rtl/bfm_dev_end.sv
// bfm_dev_end: the fifo device end: two queues, two mailboxes, ready flags, queue resets
// assumes: host end on the same pclk drives the port controls; one transfer per port per edge
//
// Function
// RL1: port B mailbox select redirects transfers to mailbox
// RL2: port B drives a-to-b mailbox or forward queue
// RL3: port A mailbox write drives its flag low
// RL4: full a-to-b mailbox ignores further writes
// RL5: port B mailbox read sets flag high
// RL6: forward queue reset forces a-to-b flag high
// RL7: port B mailbox write lowers flag, blocks rewrites
// RL8: port A mailbox read or reverse reset raises
// RL9: port A ready low when reverse queue empty
// RL10: port A ready high means valid output word
// RL11: reverse reset clears; ready rises third edge
// RL12: port B ready low on empty forward queue
// RL13: forward reset clears; ready rises third edge
// RL14: host holds forward reset four edges
// RL15: forward reset release latches offset selects
// RL16: host resets forward queue before writing
// RL17: reverse reset four edges, release latches selects
// RL18: host resets reverse queue before writing
// RL19: port A high writes, low reads, floats
// RL20: port B low writes, high reads, floats
// RL21: port B transfers only with its enable
// RL22: port A drives b-to-a mailbox or reverse queue
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bfm_dev_end (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins toward the host end
  bfm_if.dev        pins
);
  import bfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bfm_queue_s        fwd;
    bfm_queue_s        rev;
    logic [DATA_W-1:0] a2b_mail;
    logic [DATA_W-1:0] b2a_mail;
    logic              a2b_full_n;
    logic              b2a_full_n;
  } bfm_dev_state_s;

  bfm_dev_state_s st_reg;
  bfm_dev_state_s st_next;

  logic a_wr;
  logic a_rd;
  logic b_wr;
  logic b_rd;
  logic a_mbx;
  logic b_mbx;

  ////////////////////////////////////////////////////////////////////////////////
  // one queue for one edge

  function automatic bfm_queue_s q_step(
    input bfm_queue_s          q,
    input logic                rst_n,
    input logic                push,
    input logic                pop,
    input logic [DATA_W-1:0]   din,
    input logic [OFFSEL_W-1:0] fs
  );
    bfm_queue_s       n;
    logic [CNT_W-1:0] cnt;
    n   = q;
    cnt = q.count;
    if (!rst_n) begin
      n.count    = '0;
      n.wr_ptr   = '0;
      n.rd_ptr   = '0;
      n.ready    = 1'b0; // RL11 RL13
      n.delay    = '0;
      n.live     = 1'b0;
      n.rst_high = 1'b0;
      if (q.rst_edges != RESET_EDGES) begin
        n.rst_edges = 3'(q.rst_edges + 3'h1);
      end
    end else begin
      n.rst_high = 1'b1;
      // first edge after the release: the selects are taken here, one edge late
      if (!q.rst_high) begin
        n.offset_sel = fs; // RL15 RL17
        // a reset held too short leaves the queue refusing data
        n.live       = (q.rst_edges == RESET_EDGES); // RL17
        n.rst_edges  = '0;
      end
      if (q.ready && pop) begin
        if (cnt != '0) begin
          n.out    = q.mem[q.rd_ptr];
          n.rd_ptr = PTR_W'(q.rd_ptr + 1'b1);
          cnt      = CNT_W'(cnt - 1'b1);
        end else begin
          n.ready = 1'b0; // RL9 RL12
        end
      end else if (!q.ready && cnt != '0) begin
        if (q.delay == READY_DELAY) begin
          // word is loaded into the output register in the edge the flag rises
          n.out    = q.mem[q.rd_ptr]; // RL10
          n.rd_ptr = PTR_W'(q.rd_ptr + 1'b1);
          cnt      = CNT_W'(cnt - 1'b1);
          n.ready  = 1'b1; // RL11 RL13
          n.delay  = '0;
        end else begin
          n.delay = 2'(q.delay + 2'h1);
        end
      end
      // full test on the old count: a word freed this edge is reused next edge
      if (push && q.live && q.count != QUEUE_FULL) begin
        n.mem[q.wr_ptr] = din;
        n.wr_ptr        = PTR_W'(q.wr_ptr + 1'b1);
        cnt             = CNT_W'(cnt + 1'b1);
      end
      n.count = cnt;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // port decode

  always_comb begin
    a_mbx = pins.port_a_mailbox_select;
    b_mbx = pins.port_b_mailbox_select;
    a_wr  = pins.port_a_enable & pins.port_a_write_not_read; // RL19
    a_rd  = pins.port_a_enable & ~pins.port_a_write_not_read; // RL19
    b_wr  = pins.port_b_enable & ~pins.port_b_read_not_write; // RL20 RL21
    b_rd  = pins.port_b_enable & pins.port_b_read_not_write; // RL20 RL21
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;

    st_next.fwd = q_step(st_reg.fwd, pins.fwd_fifo_reset_n,
                         a_wr & ~a_mbx, // RL1
                         b_rd & ~b_mbx, // RL1 RL12
                         pins.port_a_data,
                         {pins.offset_select_hi, pins.offset_select_lo});
    st_next.rev = q_step(st_reg.rev, pins.rev_fifo_reset_n,
                         b_wr & ~b_mbx, // RL1
                         a_rd & ~a_mbx, // RL9
                         pins.port_b_data,
                         {pins.offset_select_hi, pins.offset_select_lo});

    // the read is applied first so a write in the same edge wins, if the old flag showed the mailbox empty
    if (b_rd && b_mbx) begin
      st_next.a2b_full_n = 1'b1; // RL5
    end
    if (a_wr && a_mbx && st_reg.a2b_full_n) begin
      st_next.a2b_mail   = pins.port_a_data; // RL4
      st_next.a2b_full_n = 1'b0; // RL3
    end
    if (!pins.fwd_fifo_reset_n) begin
      st_next.a2b_full_n = 1'b1; // RL6
    end

    if (a_rd && a_mbx) begin
      st_next.b2a_full_n = 1'b1; // RL8
    end
    if (b_wr && b_mbx && st_reg.b2a_full_n) begin
      st_next.b2a_mail   = pins.port_b_data; // RL1 RL7
      st_next.b2a_full_n = 1'b0; // RL7
    end
    if (!pins.rev_fifo_reset_n) begin
      st_next.b2a_full_n = 1'b1; // RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg            <= '0;
      st_reg.a2b_full_n <= 1'b1;
      st_reg.b2a_full_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // the bus select is live: a select change moves the driven word without an edge
  assign pins.dev_a_data = a_mbx ? st_reg.b2a_mail : st_reg.rev.out; // RL22
  assign pins.dev_a_oe   = ~pins.port_a_write_not_read; // RL19
  assign pins.dev_b_data = b_mbx ? st_reg.a2b_mail : st_reg.fwd.out; // RL2
  assign pins.dev_b_oe   = pins.port_b_read_not_write; // RL20

  assign pins.port_a_output_ready = st_reg.rev.ready;
  assign pins.port_b_output_ready = st_reg.fwd.ready;
  assign pins.a_to_b_mail_full_n  = st_reg.a2b_full_n;
  assign pins.b_to_a_mail_full_n  = st_reg.b2a_full_n;
  assign pins.fwd_offset_sel      = st_reg.fwd.offset_sel;
  assign pins.rev_offset_sel      = st_reg.rev.offset_sel;

endmodule
`default_nettype wire

// >>> rtl/bfm_pkg.sv
// bfm_pkg: constants and types shared by both ends of the two-way fifo mailbox link
// assumes: both ends and the link run on one clock, pclk
package bfm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // data path and queues
  localparam int             DATA_W        = 36;
  localparam int             QUEUE_DEPTH_N = 256;
  localparam int             PTR_W         = 8;
  localparam int             CNT_W         = 9;
  localparam logic [8:0]     QUEUE_FULL    = 9'h100;
  localparam int             OFFSEL_W      = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: a queue reset needs this many edges with its reset low
  localparam logic [2:0]     RESET_EDGES   = 3'h4;
  // output ready rises on the third edge after a word lands in an empty queue
  localparam logic [1:0]     READY_DELAY   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // host controller registers on apb
  localparam int             APB_ADDR_W    = 8;
  localparam logic [7:0]     CTRL_OFS      = 8'h00;
  localparam logic [7:0]     WDATA_LO_OFS  = 8'h04;
  localparam logic [7:0]     WDATA_HI_OFS  = 8'h08;
  localparam logic [7:0]     RDATA_LO_OFS  = 8'h0c;
  localparam logic [7:0]     RDATA_HI_OFS  = 8'h10;
  localparam logic [7:0]     STATUS_OFS    = 8'h14;
  localparam int             CTRL_GO       = 0;
  localparam int             CTRL_PORT_B   = 1;
  localparam int             CTRL_WRITE    = 2;
  localparam int             CTRL_MAILBOX  = 3;
  localparam int             CTRL_RST_FWD  = 4;
  localparam int             CTRL_RST_REV  = 5;
  localparam int             CTRL_FS_LO    = 6;
  localparam int             CTRL_FS_HI    = 7;
  localparam int             HI_W          = DATA_W - 32;

  ////////////////////////////////////////////////////////////////////////////////
  // one direction of storage with its ready flag and reset sequencing
  typedef struct packed {
    logic [QUEUE_DEPTH_N-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0]                     wr_ptr;
    logic [PTR_W-1:0]                     rd_ptr;
    logic [CNT_W-1:0]                     count;
    logic [DATA_W-1:0]                    out;
    logic                                 ready;
    logic [1:0]                           delay;
    logic [2:0]                           rst_edges;
    logic                                 rst_high;
    logic                                 live;
    logic [OFFSEL_W-1:0]                  offset_sel;
  } bfm_queue_s;

  typedef enum logic [1:0] {
    HOST_RESET,
    HOST_IDLE,
    HOST_XFER
  } bfm_host_state_e;

endpackage

// >>> rtl/bfm_if.sv
// bfm_if: pins between the fifo device end and its host end
// assumes: both ends clocked by the same pclk; this interface resolves the data buses
`timescale 1ns/1ps
`default_nettype none
interface bfm_if;
  import bfm_pkg::*;

  logic                port_a_enable;
  logic                port_a_write_not_read;
  logic                port_a_mailbox_select;
  logic                port_b_enable;
  logic                port_b_read_not_write;
  logic                port_b_mailbox_select;
  logic                fwd_fifo_reset_n;
  logic                rev_fifo_reset_n;
  logic                offset_select_lo;
  logic                offset_select_hi;
  logic [DATA_W-1:0]   host_a_data;
  logic                host_a_oe;
  logic [DATA_W-1:0]   host_b_data;
  logic                host_b_oe;
  logic [DATA_W-1:0]   dev_a_data;
  logic                dev_a_oe;
  logic [DATA_W-1:0]   dev_b_data;
  logic                dev_b_oe;
  logic [DATA_W-1:0]   port_a_data;
  logic [DATA_W-1:0]   port_b_data;
  logic                port_a_output_ready;
  logic                port_b_output_ready;
  logic                a_to_b_mail_full_n;
  logic                b_to_a_mail_full_n;
  logic [OFFSEL_W-1:0] fwd_offset_sel;
  logic [OFFSEL_W-1:0] rev_offset_sel;

  // a floating bus reads as zero here
  assign port_a_data = dev_a_oe ? dev_a_data : (host_a_oe ? host_a_data : '0);
  assign port_b_data = dev_b_oe ? dev_b_data : (host_b_oe ? host_b_data : '0);

  modport dev (
    input  port_a_enable, port_a_write_not_read, port_a_mailbox_select,
    input  port_b_enable, port_b_read_not_write, port_b_mailbox_select,
    input  fwd_fifo_reset_n, rev_fifo_reset_n, offset_select_lo, offset_select_hi,
    input  port_a_data, port_b_data,
    output dev_a_data, dev_a_oe, dev_b_data, dev_b_oe,
    output port_a_output_ready, port_b_output_ready,
    output a_to_b_mail_full_n, b_to_a_mail_full_n, fwd_offset_sel, rev_offset_sel
  );

  modport host (
    output port_a_enable, port_a_write_not_read, port_a_mailbox_select,
    output port_b_enable, port_b_read_not_write, port_b_mailbox_select,
    output fwd_fifo_reset_n, rev_fifo_reset_n, offset_select_lo, offset_select_hi,
    output host_a_data, host_a_oe, host_b_data, host_b_oe,
    input  port_a_data, port_b_data,
    input  port_a_output_ready, port_b_output_ready,
    input  a_to_b_mail_full_n, b_to_a_mail_full_n, fwd_offset_sel, rev_offset_sel
  );
endinterface
`default_nettype wire

// >>> rtl/bfm_host_end.sv
// bfm_host_end: host end of the fifo link, ordered by software through apb registers
// assumes: device end on the same pclk; apb master on the same pclk
`timescale 1ns/1ps
`default_nettype none
module bfm_host_end (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [bfm_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // pins toward the device end
  bfm_if.host                            pins
);
  import bfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bfm_host_state_e     st;
    logic [2:0]          cnt;
    logic                fwd_rst_n;
    logic                rev_rst_n;
    logic [OFFSEL_W-1:0] fs;
    logic                a_en;
    logic                a_wnr;
    logic                a_mbx;
    logic                b_en;
    logic                b_rnw;
    logic                b_mbx;
    logic [DATA_W-1:0]   dout;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
  } bfm_host_state_s;

  bfm_host_state_s st_reg;
  bfm_host_state_s st_next;

  logic wr_take;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb begin
    mapped = (paddr <= STATUS_OFS) && (paddr[1:0] == 2'h0);
    wr_take = psel & penable & pwrite & mapped;
    pready  = 1'b1;
    pslverr = psel & penable & ~mapped;
    prdata  = '0;
    case (paddr)
      WDATA_LO_OFS: prdata = st_reg.wdata[31:0];
      WDATA_HI_OFS: prdata = {{(32 - HI_W){1'b0}}, st_reg.wdata[DATA_W-1:32]};
      RDATA_LO_OFS: prdata = st_reg.rdata[31:0];
      RDATA_HI_OFS: prdata = {{(32 - HI_W){1'b0}}, st_reg.rdata[DATA_W-1:32]};
      STATUS_OFS:   prdata = {23'h0, pins.rev_offset_sel, pins.fwd_offset_sel,
                              pins.b_to_a_mail_full_n, pins.a_to_b_mail_full_n,
                              pins.port_b_output_ready, pins.port_a_output_ready,
                              (st_reg.st != HOST_IDLE)};
      default:      prdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    if (wr_take && paddr == WDATA_LO_OFS) begin
      st_next.wdata[31:0] = pwdata;
    end
    if (wr_take && paddr == WDATA_HI_OFS) begin
      st_next.wdata[DATA_W-1:32] = pwdata[HI_W-1:0];
    end
    case (st_reg.st)
      HOST_RESET: begin
        // low for edges cnt = 0..3 as seen by the device
        st_next.cnt = 3'(st_reg.cnt + 3'h1);
        if (st_reg.cnt == 3'(RESET_EDGES - 3'h1)) begin
          st_next.fwd_rst_n = 1'b1; // RL14
          st_next.rev_rst_n = 1'b1; // RL17
          st_next.st        = HOST_IDLE;
        end
      end
      HOST_IDLE: begin
        // a command while busy is dropped; software polls the busy bit
        if (wr_take && paddr == CTRL_OFS) begin
          if (pwdata[CTRL_RST_FWD] || pwdata[CTRL_RST_REV]) begin
            st_next.fwd_rst_n = ~pwdata[CTRL_RST_FWD];
            st_next.rev_rst_n = ~pwdata[CTRL_RST_REV];
            st_next.fs        = {pwdata[CTRL_FS_HI], pwdata[CTRL_FS_LO]};
            st_next.cnt       = '0;
            st_next.st        = HOST_RESET;
          end else if (pwdata[CTRL_GO]) begin
            st_next.dout = st_reg.wdata;
            if (pwdata[CTRL_PORT_B]) begin
              st_next.b_en  = 1'b1; // RL21
              st_next.b_rnw = ~pwdata[CTRL_WRITE]; // RL20
              st_next.b_mbx = pwdata[CTRL_MAILBOX];
            end else begin
              st_next.a_en  = 1'b1;
              st_next.a_wnr = pwdata[CTRL_WRITE]; // RL19
              st_next.a_mbx = pwdata[CTRL_MAILBOX];
            end
            st_next.st = HOST_XFER;
          end
        end
      end
      HOST_XFER: begin
        if (st_reg.a_en && !st_reg.a_wnr) begin
          st_next.rdata = pins.port_a_data;
        end
        if (st_reg.b_en && st_reg.b_rnw) begin
          st_next.rdata = pins.port_b_data;
        end
        st_next.a_en  = 1'b0;
        st_next.b_en  = 1'b0;
        st_next.a_wnr = 1'b1;
        st_next.b_rnw = 1'b0;
        st_next.a_mbx = 1'b0;
        st_next.b_mbx = 1'b0;
        st_next.st    = HOST_IDLE;
      end
      default: st_next.st = HOST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers: both queues are reset right after power-up

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0; // RL16 RL18
      st_reg.st    <= HOST_RESET;
      st_reg.a_wnr <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pins.port_a_enable         = st_reg.a_en;
  assign pins.port_a_write_not_read = st_reg.a_wnr;
  assign pins.port_a_mailbox_select = st_reg.a_mbx;
  assign pins.port_b_enable         = st_reg.b_en;
  assign pins.port_b_read_not_write = st_reg.b_rnw;
  assign pins.port_b_mailbox_select = st_reg.b_mbx;
  assign pins.fwd_fifo_reset_n      = st_reg.fwd_rst_n;
  assign pins.rev_fifo_reset_n      = st_reg.rev_rst_n;
  assign pins.offset_select_lo      = st_reg.fs[0];
  assign pins.offset_select_hi      = st_reg.fs[1];
  assign pins.host_a_data           = st_reg.dout;
  assign pins.host_a_oe             = st_reg.a_wnr; // RL19
  assign pins.host_b_data           = st_reg.dout;
  assign pins.host_b_oe             = ~st_reg.b_rnw; // RL20

endmodule
`default_nettype wire

// >>> verification/bfm_props.sv
// bfm_props: assertions on the link between the host end and the device end
// assumes: instantiated in tb beside the interface, one clock pclk
`timescale 1ns/1ps
`default_nettype none
module bfm_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // port controls from the host end
  input wire logic port_a_enable,
  input wire logic port_a_write_not_read,
  input wire logic port_a_mailbox_select,
  input wire logic port_b_enable,
  input wire logic port_b_read_not_write,
  input wire logic port_b_mailbox_select,
  input wire logic fwd_fifo_reset_n,
  input wire logic rev_fifo_reset_n,
  // flags and drives of the device end
  input wire logic dev_a_oe,
  input wire logic dev_b_oe,
  input wire logic port_a_output_ready,
  input wire logic port_b_output_ready,
  input wire logic a_to_b_mail_full_n,
  input wire logic b_to_a_mail_full_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic a_mb;
  logic b_mb;
  assign a_mb = port_a_enable && port_a_mailbox_select;
  assign b_mb = port_b_enable && port_b_mailbox_select;
  //////////////////////////////////////////////////////////////////////////////
  ab_write_low_a: assert property (
    a_mb && port_a_write_not_read && a_to_b_mail_full_n && fwd_fifo_reset_n
    |=> !a_to_b_mail_full_n) else $error("a-to-b flag not lowered by write");
  ab_hold_low_a: assert property (
    !a_to_b_mail_full_n && !(b_mb && port_b_read_not_write) && fwd_fifo_reset_n
    |=> !a_to_b_mail_full_n) else $error("a-to-b flag rose without a read");
  ab_read_high_a: assert property (
    b_mb && port_b_read_not_write && !a_to_b_mail_full_n
    |=> a_to_b_mail_full_n) else $error("a-to-b flag not raised by read");
  fwd_reset_a: assert property (
    !fwd_fifo_reset_n |=> a_to_b_mail_full_n && !port_b_output_ready)
    else $error("forward reset left flags wrong");
  ba_write_low_a: assert property (
    b_mb && !port_b_read_not_write && b_to_a_mail_full_n && rev_fifo_reset_n
    |=> !b_to_a_mail_full_n) else $error("b-to-a flag not lowered by write");
  ba_read_high_a: assert property (
    a_mb && !port_a_write_not_read && !b_to_a_mail_full_n
    |=> b_to_a_mail_full_n) else $error("b-to-a flag not raised by read");
  rev_reset_a: assert property (
    !rev_fifo_reset_n |=> b_to_a_mail_full_n && !port_a_output_ready)
    else $error("reverse reset left flags wrong");
  a_float_a: assert property (
    dev_a_oe != port_a_write_not_read) else $error("port a drive wrong");
  b_float_a: assert property (
    dev_b_oe == port_b_read_not_write) else $error("port b drive wrong");
  b_ready_delay_a: assert property (
    $rose(port_b_output_ready) |->
    $past(port_a_enable && port_a_write_not_read && !port_a_mailbox_select, 4))
    else $error("port b ready rose at the wrong edge");
  a_ready_delay_a: assert property (
    $rose(port_a_output_ready) |->
    $past(port_b_enable && !port_b_read_not_write && !port_b_mailbox_select, 4))
    else $error("port a ready rose at the wrong edge");
endmodule
`default_nettype wire

// >>> verification/tb.sv
// tb: orders the host end over apb and judges the link through its status
// assumes: both ends and the checker share pclk at 50 MHz
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module tb;
  import bfm_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [DATA_W-1:0]     w;
  int                    errors, checked, cycles;
  bfm_if bfm_if_inst ();
  bfm_dev_end bfm_dev_end_inst (.pclk(pclk), .presetn(presetn), .pins(bfm_if_inst));
  bfm_host_end bfm_host_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(bfm_if_inst));
  bfm_props bfm_props_inst (.pclk(pclk), .presetn(presetn),
    .port_a_enable(bfm_if_inst.port_a_enable),
    .port_a_write_not_read(bfm_if_inst.port_a_write_not_read),
    .port_a_mailbox_select(bfm_if_inst.port_a_mailbox_select),
    .port_b_enable(bfm_if_inst.port_b_enable),
    .port_b_read_not_write(bfm_if_inst.port_b_read_not_write),
    .port_b_mailbox_select(bfm_if_inst.port_b_mailbox_select),
    .fwd_fifo_reset_n(bfm_if_inst.fwd_fifo_reset_n),
    .rev_fifo_reset_n(bfm_if_inst.rev_fifo_reset_n),
    .dev_a_oe(bfm_if_inst.dev_a_oe), .dev_b_oe(bfm_if_inst.dev_b_oe),
    .port_a_output_ready(bfm_if_inst.port_a_output_ready),
    .port_b_output_ready(bfm_if_inst.port_b_output_ready),
    .a_to_b_mail_full_n(bfm_if_inst.a_to_b_mail_full_n),
    .b_to_a_mail_full_n(bfm_if_inst.b_to_a_mail_full_n));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // apb master: an idle cycle before each setup keeps psel from two writes per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the cycle ceiling of the bench ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat();
    apb(1'b0, STATUS_OFS, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c);
    if (c != 8'h00) apb(1'b1, CTRL_OFS, {24'h0, c});
    // a host that never leaves busy runs into the cycle ceiling and fails
    do begin
      stat();
    end while (rd[0] !== 1'b0);
    // ready needs three edges after a word lands
    repeat (4) @(posedge pclk);
  endtask
  task automatic put(input logic [DATA_W-1:0] v);
    apb(1'b1, WDATA_LO_OFS, v[31:0]);
    apb(1'b1, WDATA_HI_OFS, {28'h0, v[DATA_W-1:32]});
  endtask
  task automatic get();
    apb(1'b0, RDATA_LO_OFS, 32'h0);
    w[31:0] = rd;
    apb(1'b0, RDATA_HI_OFS, 32'h0);
    w[DATA_W-1:32] = rd[HI_W-1:0];
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // command codes: 0d/0f mailbox write a/b, 09/0b mailbox read a/b, 05/07 queue write
  task automatic t_mail_ab();
    put(36'h912345678);
    cmd(8'h0d);
    stat();
    `CHK("mail_ab_n", 1'b0, rd[3])
    put(36'h6deadbeef);
    cmd(8'h0d);
    cmd(8'h0b);
    get();
    `CHK("mail_ab", 36'h912345678, w)
    stat();
    `CHK("mail_ab_n", 1'b1, rd[3])
    $display("test mail_ab done");
  endtask
  task automatic t_mail_ba();
    put(36'ha5a5a5a5a);
    cmd(8'h0f);
    stat();
    `CHK("mail_ba_n", 1'b0, rd[4])
    put(36'h011111111);
    cmd(8'h0f);
    cmd(8'h09);
    get();
    `CHK("mail_ba", 36'ha5a5a5a5a, w)
    stat();
    `CHK("mail_ba_n", 1'b1, rd[4])
    $display("test mail_ba done");
  endtask
  task automatic t_queues();
    put(36'h100000001);
    cmd(8'h05);
    put(36'h200000002);
    cmd(8'h05);
    put(36'hf0000000f);
    cmd(8'h07);
    stat();
    `CHK("ready_b", 1'b1, rd[2])
    `CHK("ready_a", 1'b1, rd[1])
    cmd(8'h03);
    get();
    `CHK("fwd_word0", 36'h100000001, w)
    cmd(8'h03);
    get();
    `CHK("fwd_word1", 36'h200000002, w)
    cmd(8'h01);
    get();
    `CHK("rev_word", 36'hf0000000f, w)
    stat();
    `CHK("ready_b", 1'b0, rd[2])
    `CHK("ready_a", 1'b0, rd[1])
    `CHK("mail_ab_n", 1'b1, rd[3])
    $display("test queues done");
  endtask
  task automatic t_queue_reset();
    put(36'h555555555);
    cmd(8'h05);
    cmd(8'h0d);
    cmd(8'h91);
    stat();
    `CHK("ready_b", 1'b0, rd[2])
    `CHK("mail_ab_n", 1'b1, rd[3])
    `CHK("fwd_sel", 2'h2, rd[6:5])
    cmd(8'h07);
    cmd(8'h0f);
    cmd(8'h61);
    stat();
    `CHK("ready_a", 1'b0, rd[1])
    `CHK("mail_ba_n", 1'b1, rd[4])
    `CHK("rev_sel", 2'h1, rd[8:7])
    `CHK("fwd_sel", 2'h2, rd[6:5])
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, last_err)
    $display("test queue_reset done");
  endtask
  task automatic t_startup();
    cmd(8'h00);
    stat();
    `CHK("ready_a", 1'b0, rd[1])
    `CHK("ready_b", 1'b0, rd[2])
    `CHK("mail_ab_n", 1'b1, rd[3])
    `CHK("mail_ba_n", 1'b1, rd[4])
    $display("test startup done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_startup();
    t_mail_ab();
    t_mail_ba();
    t_queues();
    t_queue_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
